// ===== design/load_agen_pkg.sv
// shared constants and types of the load address generator
package load_agen_pkg;
  localparam int DATA_W = 32;
  localparam int REG_DEPTH = 32;
  localparam int BUS_AW = 9;
  // instruction field positions
  localparam int F_CREG = 29;
  localparam int F_ZERO = 28;
  localparam int F_DST = 23;
  localparam int F_BASE = 18;
  localparam int F_OFS = 13;
  localparam int F_MODE = 9;
  localparam int F_SIDE = 7;
  localparam int F_LDT = 4;
  localparam int F_OPC = 2;
  localparam int F_FILE = 1;
  localparam int MODE_REG_BIT = 2;
  localparam logic [1:0] LOAD_OPCODE = 2'h1;
  // load type codes
  localparam logic [2:0] LT_SBYTE = 3'h2;
  localparam logic [2:0] LT_UBYTE = 3'h1;
  localparam logic [2:0] LT_SHALF = 3'h4;
  localparam logic [2:0] LT_UHALF = 3'h0;
  localparam logic [2:0] LT_WORD = 3'h6;
  localparam logic [1:0] SH_BYTE = 2'h0;
  localparam logic [1:0] SH_HALF = 2'h1;
  localparam logic [1:0] SH_WORD = 2'h2;
  // addressing modes, index register then short constant
  localparam logic [3:0] M_R_POS = 4'h5, M_R_NEG = 4'h4, M_R_PRI = 4'hd;
  localparam logic [3:0] M_R_PRD = 4'hc, M_R_POI = 4'hf, M_R_POD = 4'he;
  localparam logic [3:0] M_K_POS = 4'h1, M_K_NEG = 4'h0, M_K_PRI = 4'h9;
  localparam logic [3:0] M_K_PRD = 4'h8, M_K_POI = 4'hb, M_K_POD = 4'ha;
  // condition register codes
  localparam logic [2:0] CR_NONE = 3'h0, CR_B0 = 3'h1, CR_B1 = 3'h2;
  localparam logic [2:0] CR_B2 = 3'h3, CR_A1 = 3'h4, CR_A2 = 3'h5;
  // register map (byte addresses)
  localparam logic [8:0] OFS_AMR = 9'h000;
  localparam logic [8:0] OFS_STATUS = 9'h004;
  localparam logic [8:0] OFS_LAST_ADDR = 9'h008;
  localparam logic [8:0] OFS_COUNT = 9'h00c;
  localparam logic [1:0] WIN_FILE_A = 2'h1;
  localparam logic [1:0] WIN_FILE_B = 2'h2;
  localparam logic [31:0] AMR_RESET = 32'h0;
  localparam int AMR_BK0 = 16;
  localparam int AMR_BK1 = 21;
  localparam logic [2:0] CIRC_GROUP = 3'h1;
  localparam logic [1:0] AMR_LIN = 2'h0, AMR_USE_BK0 = 2'h1, AMR_USE_BK1 = 2'h2;
  localparam int ST_REJECT = 0;
  localparam int ST_SKIP = 1;

  typedef enum {S_IDLE, S_COND, S_BASE, S_INDEX, S_OFS, S_CALC, S_MEM, S_WBBASE,
                S_WBDST, S_BUSRD, S_BUSACK} state_t;
  typedef struct packed {logic ok; logic useConst; logic sub; logic modify; logic post;} mode_t;
  typedef struct packed {logic ok; logic signExt; logic [1:0] shift;} ldtype_t;
  typedef struct packed {logic ok; logic uncond; logic fileB; logic [4:0] idx;} cond_t;
endpackage

// ===== design/agen_if.sv
// carrier between the load sequencer and the address arithmetic
`timescale 1ns/10ps
`default_nettype none
interface agen_if;
  logic [31:0] base;
  logic [31:0] offset;
  logic [1:0] shift;
  logic sub;
  logic circular;
  logic [4:0] blockBits;
  logic [31:0] result;
  modport requester(output base, offset, shift, sub, circular, blockBits, input result);
  modport generator(input base, offset, shift, sub, circular, blockBits, output result);
endinterface
`default_nettype wire

// ===== design/register_memory.sv
// one register file with a registered read port and one write port
`timescale 1ns/10ps
`default_nettype none
module register_memory #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32,
  localparam int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic [AW-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData
);
  logic [WIDTH-1:0] mem [DEPTH];

  // write port; a read of the same word in that cycle returns the old value
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // registered read
  always_ff @(posedge clk) begin
    rdData <= mem[rdAddr];
  end
endmodule // register_memory
`default_nettype wire

// ===== design/address_generator.sv
// scaled add or subtract with optional circular wrap
`timescale 1ns/10ps
`default_nettype none
module address_generator (
  agen_if.generator ag
);
  logic [31:0] scaled;
  logic [31:0] linear;
  logic [31:0] mask;

  // block size is 2^(N+1) bytes; only bits inside the block move
  always_comb begin
    scaled = ag.offset << ag.shift;
    linear = ag.sub ? ag.base - scaled : ag.base + scaled;
    mask = (32'h2 << ag.blockBits) - 32'h1;
    ag.result = ag.circular ? ((ag.base & ~mask) | (linear & mask)) : linear;
  end
endmodule // address_generator
`default_nettype wire

// ===== design/load_address_generator.sv
// load unit: decode, address generation, data extension, register bus
//
// Added by the designer: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
`default_nettype none

module load_address_generator
  import load_agen_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic instrValid,
  input wire logic [31:0] instrWord,
  output logic instrReady,
  output logic memRead,
  output logic [31:0] memAddress,
  input wire logic [31:0] memReadData,
  input wire logic memReadValid,
  output logic loadDone,
  input wire logic [BUS_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  state_t state_reg, state_next;
  logic [31:0] instr_reg, baseValue_reg, offset_reg, result_reg, loadData_reg;
  logic [31:0] amr_reg, lastAddr_reg, count_reg, readData_reg, memAddress_reg;
  logic [1:0] status_reg;
  logic instrReady_reg, memRead_reg, loadDone_reg, wait_reg;
  mode_t modeInfo, newMode;
  ldtype_t ldInfo, newType;
  cond_t condInfo, newCond;
  logic takeInstr, busGo, hitA, hitB, hitFile, condTrue;
  logic [4:0] rfRdAddr, rfWrAddr;
  logic [31:0] rfWrData, loadExt;
  logic [31:0] rfRdData [2];
  logic rfWrEn [2];
  logic [7:0] loadByte;
  logic [15:0] loadHalf;
  logic [1:0] amrField;
  agen_if agenBus();

  // mode field decode, shared by acceptance and sequencing
  // mode code decode
  function automatic mode_t decodeMode(input logic [3:0] m);
    mode_t d;
    d = '0;
    d.ok = 1'b1;
    d.useConst = ~m[MODE_REG_BIT];
    case (m)
      M_R_POS, M_K_POS: d.sub = 1'b0;
      M_R_NEG, M_K_NEG: d.sub = 1'b1;
      M_R_PRI, M_K_PRI: d.modify = 1'b1;
      M_R_PRD, M_K_PRD: d = '{1'b1, ~m[MODE_REG_BIT], 1'b1, 1'b1, 1'b0};
      M_R_POI, M_K_POI: d = '{1'b1, ~m[MODE_REG_BIT], 1'b0, 1'b1, 1'b1};
      M_R_POD, M_K_POD: d = '{1'b1, ~m[MODE_REG_BIT], 1'b1, 1'b1, 1'b1};
      default: d.ok = 1'b0;
    endcase
    return d;
  endfunction

  // load type decode; store codes fall to the default and are refused
  // load type codes
  function automatic ldtype_t decodeType(input logic [2:0] t);
    case (t)
      LT_SBYTE: return '{1'b1, 1'b1, SH_BYTE};
      LT_UBYTE: return '{1'b1, 1'b0, SH_BYTE};
      LT_SHALF: return '{1'b1, 1'b1, SH_HALF};
      LT_UHALF: return '{1'b1, 1'b0, SH_HALF};
      LT_WORD: return '{1'b1, 1'b0, SH_WORD};
      default: return '0;
    endcase
  endfunction

  // condition register decode
  function automatic cond_t decodeCond(input logic [2:0] c);
    case (c)
      CR_NONE: return '{1'b1, 1'b1, 1'b0, 5'h00};
      CR_B0: return '{1'b1, 1'b0, 1'b1, 5'h00};
      CR_B1: return '{1'b1, 1'b0, 1'b1, 5'h01};
      CR_B2: return '{1'b1, 1'b0, 1'b1, 5'h02};
      CR_A1: return '{1'b1, 1'b0, 1'b0, 5'h01};
      CR_A2: return '{1'b1, 1'b0, 1'b0, 5'h02};
      default: return '0;
    endcase
  endfunction

  // byte-lane merge for bus writes of the addressing mode register
  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  // field decode of the held instruction
  // field split
  always_comb begin
    modeInfo = decodeMode(instr_reg[F_MODE +: 4]);
    ldInfo = decodeType(instr_reg[F_LDT +: 3]);
    condInfo = decodeCond(instr_reg[F_CREG +: 3]);
    condTrue = condInfo.uncond ||
               (instr_reg[F_ZERO] ? rfRdData[condInfo.fileB] == 32'h0 : rfRdData[condInfo.fileB] != 32'h0);
  end

  // acceptance and bus window decode
  always_comb begin
    takeInstr = instrValid && instrReady_reg;
    // offered word is checked before it is captured, so a refused one never leaves idle
    newMode = decodeMode(instrWord[F_MODE +: 4]);
    newType = decodeType(instrWord[F_LDT +: 3]);
    newCond = decodeCond(instrWord[F_CREG +: 3]);
    busGo = (avs_read || avs_write) && wait_reg && state_reg == S_IDLE && !takeInstr;
    hitA = avs_address[8:7] == WIN_FILE_A;
    hitB = avs_address[8:7] == WIN_FILE_B;
    hitFile = hitA || hitB;
  end

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (takeInstr) begin
          if (newMode.ok && newType.ok && newCond.ok && instrWord[F_OPC +: 2] == LOAD_OPCODE) begin
            state_next = S_COND;
          end
        end else if (busGo) begin
          state_next = (avs_read && hitFile) ? S_BUSRD : S_BUSACK;
        end
      end
      S_COND: state_next = S_BASE;
      S_BASE: state_next = condTrue ? S_INDEX : S_IDLE;
      S_INDEX: state_next = S_OFS;
      S_OFS: state_next = S_CALC;
      S_CALC: state_next = S_MEM;
      S_MEM: if (memReadValid) state_next = modeInfo.modify ? S_WBBASE : S_WBDST;
      S_WBBASE: state_next = S_WBDST;
      S_WBDST: state_next = S_IDLE;
      S_BUSRD: state_next = S_BUSACK;
      default: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= S_IDLE;
      instrReady_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      instrReady_reg <= state_next == S_IDLE;
    end
  end

  // instruction capture
  always_ff @(posedge clk or posedge reset) begin
    if (reset) instr_reg <= 32'h0;
    else if (takeInstr) instr_reg <= instrWord;
  end

  // register file read address per step; data arrives one cycle later
  // side selects file
  always_comb begin
    case (state_reg)
      S_COND: rfRdAddr = condInfo.idx;
      S_BASE: rfRdAddr = instr_reg[F_BASE +: 5];
      S_INDEX: rfRdAddr = instr_reg[F_OFS +: 5];
      default: rfRdAddr = avs_address[6:2];
    endcase
  end

  // base and offset capture
  // register or constant offset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      baseValue_reg <= 32'h0;
      offset_reg <= 32'h0;
    end else if (state_reg == S_INDEX) begin
      baseValue_reg <= rfRdData[instr_reg[F_SIDE]];
    end else if (state_reg == S_OFS) begin
      offset_reg <= modeInfo.useConst ? {27'h0, instr_reg[F_OFS +: 5]} : rfRdData[instr_reg[F_SIDE]];
    end
  end

  // circular lookup: only bases 4..7 carry a mode field
  // circular bases only
  always_comb begin
    amrField = amr_reg[{instr_reg[F_SIDE], instr_reg[F_BASE +: 2], 1'b0} +: 2];
    agenBus.base = baseValue_reg;
    agenBus.offset = offset_reg;
    agenBus.shift = ldInfo.shift;
    agenBus.sub = modeInfo.sub;
    agenBus.circular = instr_reg[F_BASE + 2 +: 3] == CIRC_GROUP &&
                       (amrField == AMR_USE_BK0 || amrField == AMR_USE_BK1);
    agenBus.blockBits = amrField == AMR_USE_BK1 ? amr_reg[AMR_BK1 +: 5] : amr_reg[AMR_BK0 +: 5];
  end

  address_generator uAgen (
    .ag(agenBus)
  );

  // memory request; post modes use the untouched base
  // computed access address
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      memRead_reg <= 1'b0;
      memAddress_reg <= 32'h0;
      result_reg <= 32'h0;
    end else if (state_reg == S_CALC) begin
      memRead_reg <= 1'b1;
      memAddress_reg <= modeInfo.post ? baseValue_reg : agenBus.result;
      result_reg <= agenBus.result;
    end else if (state_reg == S_MEM && memReadValid) begin
      memRead_reg <= 1'b0;
    end
  end

  // lane pick and extension of returned data, little-endian lanes
  // low bits placed
  always_comb begin
    loadByte = memReadData[{memAddress_reg[1:0], 3'h0} +: 8];
    loadHalf = memAddress_reg[1] ? memReadData[31:16] : memReadData[15:0];
    case (ldInfo.shift)
      SH_BYTE: loadExt = {{24{ldInfo.signExt & loadByte[7]}}, loadByte};
      SH_HALF: loadExt = {{16{ldInfo.signExt & loadHalf[15]}}, loadHalf};
      default: loadExt = memReadData;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) loadData_reg <= 32'h0;
    else if (state_reg == S_MEM && memReadValid) loadData_reg <= loadExt;
  end

  // register file writes: bus, base update, destination; one per cycle
  always_comb begin
    rfWrEn[0] = 1'b0;
    rfWrEn[1] = 1'b0;
    rfWrAddr = avs_address[6:2];
    rfWrData = avs_writedata;
    if (state_reg == S_WBBASE) begin
      rfWrEn[instr_reg[F_SIDE]] = 1'b1;
      rfWrAddr = instr_reg[F_BASE +: 5];
      rfWrData = result_reg;
    end else if (state_reg == S_WBDST) begin
      rfWrEn[instr_reg[F_FILE]] = 1'b1;
      rfWrAddr = instr_reg[F_DST +: 5];
      rfWrData = loadData_reg;
    end else if (busGo && avs_write && hitFile) begin
      rfWrEn[hitB] = 1'b1;
    end
  end

  for (genvar f = 0; f < 2; f++) begin : gFile
    register_memory #(.WIDTH(DATA_W), .DEPTH(REG_DEPTH)) uMem (
      .clk(clk),
      .rdAddr(rfRdAddr),
      .rdData(rfRdData[f]),
      .wrEn(rfWrEn[f]),
      .wrAddr(rfWrAddr),
      .wrData(rfWrData)
    );
  end

  // completion flags and counters; a fresh event wins over a clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      loadDone_reg <= 1'b0;
      lastAddr_reg <= 32'h0;
      count_reg <= 32'h0;
      status_reg <= 2'h0;
    end else begin
      loadDone_reg <= state_reg == S_WBDST;
      if (state_reg == S_WBDST) count_reg <= count_reg + 32'h1;
      if (state_reg == S_CALC) lastAddr_reg <= modeInfo.post ? baseValue_reg : agenBus.result;
      if (busGo && avs_write && avs_address == OFS_STATUS && avs_byteenable[0]) begin
        status_reg <= status_reg & ~avs_writedata[1:0];
      end
      if (takeInstr && state_next == S_IDLE) status_reg[ST_REJECT] <= 1'b1;
      if (state_reg == S_BASE && !condTrue) status_reg[ST_SKIP] <= 1'b1;
    end
  end

  // addressing mode register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) amr_reg <= AMR_RESET;
    else if (busGo && avs_write && avs_address == OFS_AMR) begin
      amr_reg <= mergeBytes(amr_reg, avs_writedata, avs_byteenable);
    end
  end

  // bus answer: wait drops for exactly one cycle per access
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wait_reg <= 1'b1;
      readData_reg <= 32'h0;
    end else begin
      wait_reg <= !(state_next == S_BUSACK);
      if (state_reg == S_BUSRD) readData_reg <= rfRdData[hitB];
      else if (busGo && avs_read) begin
        if (avs_address == OFS_AMR) readData_reg <= amr_reg;
        else if (avs_address == OFS_STATUS) readData_reg <= {30'h0, status_reg};
        else if (avs_address == OFS_LAST_ADDR) readData_reg <= lastAddr_reg;
        else if (avs_address == OFS_COUNT) readData_reg <= count_reg;
        else readData_reg <= 32'h0;
      end
    end
  end

  assign instrReady = instrReady_reg;
  assign memRead = memRead_reg;
  assign memAddress = memAddress_reg;
  assign loadDone = loadDone_reg;
  assign avs_readdata = readData_reg;
  assign avs_waitrequest = wait_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence sCalc;
    state_reg == S_CALC;
  endsequence
  sequence sMemUp;
    memRead_reg && state_reg == S_MEM;
  endsequence

  a_mem_issue: assert property (sCalc |=> sMemUp)
    else $error("memory read not raised after address step");
  a_pre_address: assert property (sCalc ##0 !modeInfo.post |=> memAddress_reg == result_reg)
    else $error("offset mode address differs from result");
  a_post_address: assert property (sCalc ##0 modeInfo.post |=> memAddress_reg == baseValue_reg)
    else $error("post mode address is not the old base");
  a_base_writeback: assert property (state_reg == S_WBBASE |-> rfWrEn[instr_reg[F_SIDE]]
                                     && rfWrData == result_reg && modeInfo.modify)
    else $error("base write back wrong");
  a_word_scaled: assert property (sCalc ##0 (ldInfo.shift == SH_WORD && !modeInfo.sub && !agenBus.circular)
                                  |-> agenBus.result == baseValue_reg + {offset_reg[29:0], 2'h0})
    else $error("word offset not scaled by four");
  a_half_sub: assert property (sCalc ##0 (ldInfo.shift == SH_HALF && modeInfo.sub && !agenBus.circular)
                               |-> agenBus.result == baseValue_reg - {offset_reg[30:0], 1'h0})
    else $error("halfword subtract wrong");
  a_circ_group: assert property (agenBus.circular |-> instr_reg[F_BASE + 2 +: 3] == CIRC_GROUP)
    else $error("circular mode on a base outside 4..7");
  a_sign_fill: assert property (state_reg == S_MEM && memReadValid && ldInfo.signExt && ldInfo.shift == SH_BYTE
                                |=> loadData_reg[31:8] == {24{loadData_reg[7]}})
    else $error("byte sign fill wrong");
  a_zero_fill: assert property (state_reg == S_MEM && memReadValid && !ldInfo.signExt && ldInfo.shift == SH_HALF
                                |=> loadData_reg[31:16] == 16'h0)
    else $error("halfword zero fill wrong");
  a_word_whole: assert property (state_reg == S_MEM && memReadValid && ldInfo.shift == SH_WORD
                                 |=> loadData_reg == $past(memReadData))
    else $error("word load altered");
  a_dest_file: assert property (state_reg == S_WBDST |-> rfWrEn[instr_reg[F_FILE]]
                                && !rfWrEn[!instr_reg[F_FILE]] && rfWrData == loadData_reg)
    else $error("destination file wrong");
endmodule // load_address_generator
`default_nettype wire

// ===== sim/data_memory_model.sv
// behavioural data memory answering the load unit's read requests
`timescale 1ns/10ps
`default_nettype none
module data_memory_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic memRead,
  input wire logic [31:0] memAddress,
  input wire logic [3:0] delay,
  output logic [31:0] memReadData,
  output logic memReadValid
);
  logic [3:0] waitCount;
  // answer after a chosen wait; data toggles outside the valid cycle so stale data never passes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      waitCount <= 4'h0;
      memReadValid <= 1'b0;
      memReadData <= 32'h0;
    end else begin
      memReadValid <= 1'b0;
      memReadData <= ~memReadData;
      if (memRead && !memReadValid) begin
        if (waitCount == delay) begin
          memReadValid <= 1'b1;
          memReadData <= 32'hc3a5_8e71 + {memAddress[31:2], 2'h0};
          waitCount <= 4'h0;
        end else begin
          waitCount <= waitCount + 4'h1;
        end
      end
    end
  end
endmodule // data_memory_model
`default_nettype wire

// ===== sim/load_address_generator_tb_top.sv
// self-checking bench for the load address generator
`timescale 1ns/10ps
`default_nettype none
module load_address_generator_tb_top;
  import load_agen_pkg::*;
  logic clk, reset, instrValid, instrReady, memRead, memReadValid, loadDone;
  logic [31:0] instrWord, memAddress, memReadData, avs_writedata, avs_readdata, rd, ad;
  logic [8:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_byteenable, memDelay;
  logic [2:0] types [5];
  logic [3:0] modes [12];
  int errCount, nCompared;
  load_address_generator uut (.clk(clk), .reset(reset), .instrValid(instrValid), .instrWord(instrWord),
    .instrReady(instrReady), .memRead(memRead), .memAddress(memAddress), .memReadData(memReadData),
    .memReadValid(memReadValid), .loadDone(loadDone), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  data_memory_model mem (.clk(clk), .reset(reset), .memRead(memRead), .memAddress(memAddress),
    .delay(memDelay), .memReadData(memReadData), .memReadValid(memReadValid));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errCount++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one bus cycle held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 200);
    if (n >= 200) chk(32'h1, 32'h0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  function automatic logic [8:0] fa(input logic b, input logic [4:0] r);
    return (b ? 9'h100 : 9'h080) + {2'h0, r, 2'h0};
  endfunction
  // base and index share the unit's side; offsets always written
  function automatic logic [31:0] ins(input logic [4:0] d, b, o, input logic [3:0] m, input logic y,
                                      input logic [2:0] t, input logic s);
    return {3'h0, 1'b0, d, b, o, m, 1'b0, y, t, LOAD_OPCODE, s, 1'b0};
  endfunction
  function automatic logic [31:0] ext(input logic [2:0] t, input logic [31:0] a);
    logic [31:0] w;
    w = 32'hc3a5_8e71 + {a[31:2], 2'h0};
    w = w >> (t == LT_WORD ? 0 : (t[2] | t == LT_UHALF) ? 16 * a[1] : 8 * a[1:0]);
    case (t)
      LT_SBYTE: return {{24{w[7]}}, w[7:0]};
      LT_UBYTE: return {24'h0, w[7:0]};
      LT_SHALF: return {{16{w[15]}}, w[15:0]};
      LT_UHALF: return {16'h0, w[15:0]};
      default: return w;
    endcase
  endfunction
  // issue one instruction, capture the access address, wait for completion
  task automatic load(input logic [31:0] w, output logic [31:0] a);
    int n;
    @(posedge clk);
    instrWord <= w;
    instrValid <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (instrReady !== 1'b1 && n < 50);
    instrValid <= 1'b0;
    do begin @(posedge clk); n++; end while (memRead !== 1'b1 && n < 100);
    a = memAddress;
    do begin @(posedge clk); n++; end while (loadDone !== 1'b1 && n < 200);
    if (n >= 200) chk(32'h1, 32'h0);
  endtask
  // each load type: scaling and extension, destination in the other file
  task automatic t_types;
    for (int i = 0; i < 5; i++) begin
      bus(1, fa(0, 4), 32'h1000, rd);
      load(ins(5'd7, 5'd4, 5'd3, M_K_POS, 1'b0, types[i], 1'b1), ad);
      // scaled constant offset
      chk(ad, 32'h1000 + (32'h3 << (i < 2 ? 0 : i < 4 ? 1 : 2)));
      bus(0, fa(1, 7), 0, rd);
      // extension into file B
      chk(rd, ext(types[i], ad));
    end
    $display("test types done");
  endtask
  // all twelve modes on side B with a slow memory
  task automatic t_modes;
    logic [31:0] na;
    memDelay <= 4'h5;
    for (int i = 0; i < 12; i++) begin
      bus(1, fa(1, 5), 32'h2000, rd);
      bus(1, fa(1, 6), 32'h2, rd);
      load(ins(5'd9, 5'd5, i < 6 ? 5'd6 : 5'd2, modes[i], 1'b1, LT_WORD, 1'b0), ad);
      na = modes[i][0] ? 32'h2008 : 32'h1ff8;
      // access address per mode
      chk(ad, (modes[i][3] & modes[i][1]) ? 32'h2000 : na);
      bus(0, fa(1, 5), 0, rd);
      // base write-back only for modify modes
      chk(rd, modes[i][3] ? na : 32'h2000);
      bus(0, fa(0, 9), 0, rd);
      chk(rd, ext(LT_WORD, ad));
    end
    memDelay <= 4'h0;
    $display("test modes done");
  endtask
  // circular block on one base, then linear again
  task automatic t_circ;
    bus(0, OFS_AMR, 0, rd);
    chk(rd, AMR_RESET);
    bus(1, OFS_AMR, 32'h0003_0001, rd);
    for (int i = 0; i < 2; i++) begin
      bus(1, fa(0, 4), 32'h100c, rd);
      load(ins(5'd2, 5'd4, 5'd2, M_K_PRI, 1'b0, LT_WORD, 1'b0), ad);
      // wrap inside a 16-byte block, else linear
      chk(ad, i == 0 ? 32'h1004 : 32'h1014);
      bus(1, OFS_AMR, 32'h0, rd);
    end
    bus(0, 9'h1f0, 0, rd);
    chk(rd, 32'h0);
    // last access and completed loads: 5 types, 12 modes, 2 circular
    bus(0, OFS_LAST_ADDR, 0, rd);
    chk(rd, 32'h1014);
    bus(0, OFS_COUNT, 0, rd);
    chk(rd, 32'h13);
    $display("test circular done");
  endtask
  // undefined mode is dropped and flagged
  task automatic t_reject;
    @(posedge clk);
    instrWord <= ins(5'd1, 5'd4, 5'd1, 4'h2, 1'b0, LT_WORD, 1'b0);
    instrValid <= 1'b1;
    @(posedge clk);
    instrValid <= 1'b0;
    repeat (12) @(posedge clk);
    // no access for a refused mode
    chk({31'h0, memRead}, 32'h0);
    bus(0, OFS_STATUS, 0, rd);
    chk(rd & 32'h1, 32'h1);
    bus(1, OFS_STATUS, 32'h3, rd);
    bus(0, OFS_STATUS, 0, rd);
    chk(rd, 32'h0);
    // false condition on A1 == 0: skipped without a memory access
    bus(1, fa(0, 1), 32'h0, rd);
    @(posedge clk);
    instrWord <= ins(5'd1, 5'd4, 5'd1, M_K_POS, 1'b0, LT_WORD, 1'b0) | {CR_A1, 29'h0};
    instrValid <= 1'b1;
    @(posedge clk);
    instrValid <= 1'b0;
    repeat (12) @(posedge clk);
    chk({31'h0, memRead}, 32'h0);
    bus(0, OFS_STATUS, 0, rd);
    chk(rd, 32'h2);
    $display("test reject done");
  endtask
  initial begin
    #100000;
    errCount++;
    conclude();
  end
  initial begin
    types = '{LT_SBYTE, LT_UBYTE, LT_SHALF, LT_UHALF, LT_WORD};
    modes = '{M_R_POS, M_R_NEG, M_R_PRI, M_R_PRD, M_R_POI, M_R_POD,
              M_K_POS, M_K_NEG, M_K_PRI, M_K_PRD, M_K_POI, M_K_POD};
    errCount = 0;
    nCompared = 0;
    reset = 1'b1;
    {instrValid, avs_read, avs_write} = 3'h0;
    instrWord = 32'h0;
    avs_address = 9'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    memDelay = 4'h0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    t_types();
    t_modes();
    t_circ();
    t_reject();
    conclude();
  end
endmodule // load_address_generator_tb_top
`default_nettype wire
